//--- pkg/adc_temp_pkg.sv
// Package: register map, fields, reset values and timing for converter control
//
// Overview of operation
// [R1] Range bit one selects high sensor range
// [R2] Sensor powered only while enable bit set
// [R3] Software waits 25 us after sensor select
// [R4] Successive approximation gives 10-bit result registers
// [R5] One multiplexer feeds shared sample-and-hold
// [R6] Completion interrupt, also wakes from Sleep
// [R7] Reference internal or external, software chosen
// [R8] Factory 90 C sensor reading readable
// [R9] Software sets pin direction and analog select
// [R10] Six-bit channel field picks sampled input
// [R11] Enabled by on bit; go starts conversion
// [R12] Completion clears go, flags, loads result
package adc_temp_pkg;
   // Byte addresses on the register bus
   localparam logic [7:0] ref_sensor_off   = 8'h00;
   localparam logic [7:0] chan_ctrl_off    = 8'h04;
   localparam logic [7:0] conv_cfg_off     = 8'h08;
   localparam logic [7:0] trig_sel_off     = 8'h0C;
   localparam logic [7:0] res_high_off     = 8'h10;
   localparam logic [7:0] res_low_off      = 8'h14;
   localparam logic [7:0] status_off       = 8'h18;
   localparam logic [7:0] irq_enable_off   = 8'h1C;
   localparam logic [7:0] dev_info_off     = 8'h20;
   // Reference/sensor control fields
   localparam int fixed_ref_en_bit   = 7;
   localparam int fixed_ref_rdy_bit  = 6;
   localparam int sensor_en_bit      = 5;
   localparam int sensor_rng_bit     = 4;
   // Channel control fields
   localparam int chan_lsb           = 2;
   localparam int go_bit             = 1;
   localparam int conv_on_bit        = 0;
   // Config fields
   localparam int justify_bit        = 7;
   localparam int clk_sel_lsb        = 4;
   // Status / enable fields
   localparam int done_flag_bit      = 0;
   localparam int sleep_bit          = 1;
   // Reset values
   localparam logic [7:0] ref_sensor_rst = 8'h40;
   localparam logic [7:0] byte_rst       = 8'h00;
   // Channel reserved for the temperature sensor
   localparam logic [5:0] temp_channel   = 6'h3C;
   // Factory 90 C reading; arbitrary default value
   localparam logic [9:0] dia_temp90_default = 10'h200;
   // Timing
   localparam int clk_mhz          = 25;
   localparam int settle_us        = 25;
   localparam int settle_cycles    = settle_us * clk_mhz;
   localparam int result_bits      = 10;
   typedef enum logic [1:0] {idle_st, sample_st, convert_st} conv_state_type;
endpackage : adc_temp_pkg

//--- core/adc_clk_divider.sv
// Conversion clock divider producing one-cycle bit-time enables
module adc_clk_divider (
   input  wire logic       pclk,     // System clock
   input  wire logic       presetn,  // Async reset, active low
   input  wire logic       run,      // Divider runs while high
   input  wire logic [2:0] sel,      // Conversion clock select
   output logic            tick      // One-cycle bit-time pulse
);
   logic [6:0] cnt_reg;
   logic [6:0] limit;

   // Encoding keeps the documented odd ordering of divide ratios
   always_comb begin
      case (sel)
         3'h0:    limit = 7'h01;
         3'h4:    limit = 7'h03;
         3'h1:    limit = 7'h07;
         3'h5:    limit = 7'h0F;
         3'h2:    limit = 7'h1F;
         3'h6:    limit = 7'h3F;
         default: limit = 7'h07; // Dedicated RC stand-in
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 7'h00;
      end else if (!run || cnt_reg >= limit) begin
         cnt_reg <= 7'h00;
      end else begin
         cnt_reg <= cnt_reg + 7'h01;
      end
   end

   assign tick = run && (cnt_reg >= limit);
endmodule : adc_clk_divider

//--- core/adc_temp_indicator_control.sv
// Temperature indicator and SAR converter control with APB registers
module adc_temp_indicator_control (
   input  wire logic        pclk,          // System clock, 25 MHz
   input  wire logic        presetn,       // Async reset, active low
   input  wire logic        psel,          // APB select
   input  wire logic        penable,       // APB enable
   input  wire logic        pwrite,        // APB write
   input  wire logic [7:0]  paddr,         // APB byte address
   input  wire logic [31:0] pwdata,        // APB write data
   output logic             pready,        // APB ready
   output logic [31:0]      prdata,        // APB read data
   output logic             pslverr,       // APB error
   input  wire logic        sleep_req,     // Device in Sleep, async
   input  wire logic        cmp_in,        // Comparator result, async
   output logic [5:0]       mux_sel,       // Analog mux channel
   output logic             sample_hold,   // S/H tracking when high
   output logic [9:0]       dac_code,      // SAR trial code
   output logic             sensor_power,  // Sensor supply enable
   output logic             sensor_high,   // Sensor high range
   output logic             fixed_ref_on,  // Fixed reference enable
   output logic [1:0]       conv_ref_gain, // Converter reference gain
   output logic [1:0]       comp_ref_gain, // Comparator reference gain
   output logic [1:0]       pos_ref_sel,   // Positive reference select
   output logic             adc_power,     // Converter analog enable
   output logic             irq,           // Completion interrupt
   output logic             wake           // Wake from Sleep
);
   logic [7:0] ref_reg, chan_reg, cfg_reg, trig_reg, ien_reg;
   logic [9:0] sar_reg, res_reg;
   logic       done_reg, go_reg;
   logic [3:0] bit_reg;
   logic       cmp_s1, cmp_s2, slp_s1, slp_s2;
   logic       tick, setup_w, acc, wr, rd;
   logic       finish, abort_sw;
   adc_temp_pkg::conv_state_type state_reg;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   assign acc     = psel && penable;
   assign wr      = acc && pwrite;
   assign rd      = acc && !pwrite;
   assign pready  = 1'b1;
   assign setup_w = 1'b0;

   // Two-flop synchronisers for asynchronous inputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_s1 <= 1'b0;
         cmp_s2 <= 1'b0;
         slp_s1 <= 1'b0;
         slp_s2 <= 1'b0;
      end else begin
         cmp_s1 <= cmp_in;
         cmp_s2 <= cmp_s1;
         slp_s1 <= sleep_req;
         slp_s2 <= slp_s1;
      end
   end

   // Unmapped addresses answer with an error
   always_comb begin
      pslverr = 1'b0;
      if (acc && !(hit(paddr, adc_temp_pkg::ref_sensor_off)
            || hit(paddr, adc_temp_pkg::chan_ctrl_off)
            || hit(paddr, adc_temp_pkg::conv_cfg_off)
            || hit(paddr, adc_temp_pkg::trig_sel_off)
            || hit(paddr, adc_temp_pkg::res_high_off)
            || hit(paddr, adc_temp_pkg::res_low_off)
            || hit(paddr, adc_temp_pkg::status_off)
            || hit(paddr, adc_temp_pkg::irq_enable_off)
            || hit(paddr, adc_temp_pkg::dev_info_off))) begin
         pslverr = 1'b1;
      end
   end

   // Plain configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_reg  <= adc_temp_pkg::ref_sensor_rst;
         cfg_reg  <= adc_temp_pkg::byte_rst;
         trig_reg <= adc_temp_pkg::byte_rst;
         ien_reg  <= adc_temp_pkg::byte_rst;
      end else if (wr) begin
         if (hit(paddr, adc_temp_pkg::ref_sensor_off)) begin
            // Ready flag always reads one
            ref_reg <= pwdata[7:0] | adc_temp_pkg::ref_sensor_rst;
         end
         if (hit(paddr, adc_temp_pkg::conv_cfg_off)) begin
            cfg_reg <= {pwdata[7:4], 1'b0, 1'b0, pwdata[1:0]};
         end
         if (hit(paddr, adc_temp_pkg::trig_sel_off)) begin
            trig_reg <= {4'h0, pwdata[3:0]};
         end
         if (hit(paddr, adc_temp_pkg::irq_enable_off)) begin
            ien_reg <= {7'h00, pwdata[0]};
         end
      end
   end

   // Channel and on bits; go lives in its own flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_reg <= adc_temp_pkg::byte_rst;
      end else if (wr && hit(paddr, adc_temp_pkg::chan_ctrl_off)) begin
         chan_reg <= {pwdata[7:2], 1'b0, pwdata[0]};
      end
   end

   assign abort_sw = wr && hit(paddr, adc_temp_pkg::chan_ctrl_off)
                     && !pwdata[adc_temp_pkg::go_bit] && go_reg;
   // Sleep without the RC clock aborts the conversion
   assign finish = (state_reg == adc_temp_pkg::convert_st) && tick
                   && (bit_reg == 4'h0);

   // Go is set only when the converter is already on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         go_reg <= 1'b0;
      end else if (finish || abort_sw || !chan_reg[0]) begin
         go_reg <= 1'b0; // R12
      end else if (slp_s2 && cfg_reg[5:4] != 2'b11) begin
         go_reg <= 1'b0;
      end else if (wr && hit(paddr, adc_temp_pkg::chan_ctrl_off)
                   && pwdata[adc_temp_pkg::go_bit]
                   && pwdata[adc_temp_pkg::conv_on_bit]) begin
         go_reg <= 1'b1; // R11
      end
   end

   adc_clk_divider u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (go_reg),
      .sel     (cfg_reg[6:4]),
      .tick    (tick)
   );

   // Conversion sequencer: one sample period then ten bit trials
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= adc_temp_pkg::idle_st;
         bit_reg   <= 4'h0;
         sar_reg   <= 10'h000;
      end else begin
         case (state_reg)
            adc_temp_pkg::idle_st: begin
               if (go_reg) begin
                  state_reg <= adc_temp_pkg::sample_st;
               end
            end
            adc_temp_pkg::sample_st: begin
               if (!go_reg) begin
                  state_reg <= adc_temp_pkg::idle_st;
               end else if (tick) begin
                  state_reg <= adc_temp_pkg::convert_st;
                  bit_reg   <= 4'd9;
                  sar_reg   <= 10'h200;
               end
            end
            adc_temp_pkg::convert_st: begin
               if (!go_reg) begin
                  state_reg <= adc_temp_pkg::idle_st;
               end else if (tick) begin
                  // Keep trial bit if input at or above trial level
                  sar_reg[bit_reg] <= cmp_s2; // R4
                  if (bit_reg != 4'h0) begin
                     sar_reg[bit_reg - 4'h1] <= 1'b1;
                     bit_reg <= bit_reg - 4'h1;
                  end else begin
                     state_reg <= adc_temp_pkg::idle_st;
                  end
               end
            end
            default: state_reg <= adc_temp_pkg::idle_st;
         endcase
      end
   end

   // Result loads on completion or on a software abort during conversion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_reg <= 10'h000;
      end else if (finish) begin
         res_reg <= {sar_reg[9:1], cmp_s2}; // R12
      end else if (abort_sw && state_reg == adc_temp_pkg::convert_st) begin
         // Partial code: undecided bits left as they stand
         res_reg <= sar_reg;
      end
   end

   // Done flag: set wins over a software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_reg <= 1'b0;
      end else if (finish) begin
         done_reg <= 1'b1; // R12
      end else if (wr && hit(paddr, adc_temp_pkg::status_off)
                   && pwdata[adc_temp_pkg::done_flag_bit]) begin
         done_reg <= 1'b0;
      end
   end

   // Read mux; justify bit picks the layout
   always_comb begin
      prdata = 32'h0000_0000;
      if (rd) begin
         case (paddr)
            adc_temp_pkg::ref_sensor_off: prdata[7:0] = ref_reg;
            adc_temp_pkg::chan_ctrl_off:
               prdata[7:0] = {chan_reg[7:2], go_reg, chan_reg[0]};
            adc_temp_pkg::conv_cfg_off:   prdata[7:0] = cfg_reg;
            adc_temp_pkg::trig_sel_off:   prdata[7:0] = trig_reg;
            adc_temp_pkg::res_high_off:
               prdata[7:0] = cfg_reg[adc_temp_pkg::justify_bit]
                             ? {6'h00, res_reg[9:8]} : res_reg[9:2]; // R4
            adc_temp_pkg::res_low_off:
               prdata[7:0] = cfg_reg[adc_temp_pkg::justify_bit]
                             ? res_reg[7:0] : {res_reg[1:0], 6'h00};
            adc_temp_pkg::status_off:
               prdata[1:0] = {slp_s2, done_reg};
            adc_temp_pkg::irq_enable_off: prdata[7:0] = ien_reg;
            adc_temp_pkg::dev_info_off:
               prdata[9:0] = adc_temp_pkg::dia_temp90_default; // R8
            default: prdata = 32'h0000_0000;
         endcase
      end
   end

   assign sensor_power  = ref_reg[adc_temp_pkg::sensor_en_bit];  // R2
   assign sensor_high   = ref_reg[adc_temp_pkg::sensor_rng_bit]; // R1
   assign fixed_ref_on  = ref_reg[adc_temp_pkg::fixed_ref_en_bit];
   assign conv_ref_gain = ref_reg[1:0];
   assign comp_ref_gain = ref_reg[3:2];
   assign pos_ref_sel   = cfg_reg[1:0]; // R7
   assign mux_sel       = chan_reg[7:2]; // R10 R5
   assign adc_power     = chan_reg[adc_temp_pkg::conv_on_bit]; // R11
   assign sample_hold   = (state_reg != adc_temp_pkg::convert_st); // R5
   assign dac_code      = sar_reg;
   assign irq           = done_reg && ien_reg[0]; // R6
   assign wake          = irq && slp_s2; // R6

   chk_range_follow: assert property (@(posedge pclk) // R1
      disable iff (!presetn)
      wr && hit(paddr, adc_temp_pkg::ref_sensor_off)
      |=> sensor_high == $past(pwdata[adc_temp_pkg::sensor_rng_bit]))
      else $error("range out of step");
   chk_sensor_power: assert property (@(posedge pclk) // R2
      disable iff (!presetn)
      wr && hit(paddr, adc_temp_pkg::ref_sensor_off)
      |=> sensor_power == $past(pwdata[adc_temp_pkg::sensor_en_bit]))
      else $error("sensor power out of step");
   chk_done_sets: assert property (@(posedge pclk) disable iff (!presetn)
      finish |=> done_reg && !go_reg) else $error("finish not seen"); // R12
   chk_go_needs_on: assert property (@(posedge pclk) disable iff (!presetn)
      go_reg |-> adc_power) else $error("go with converter off"); // R11
   chk_result_load: assert property (@(posedge pclk) // R4
      disable iff (!presetn)
      finish |=> res_reg[9:1] == $past(sar_reg[9:1])
      && res_reg[0] == $past(cmp_s2))
      else $error("result not loaded");
   chk_mux_route: assert property (@(posedge pclk) // R10
      disable iff (!presetn)
      wr && hit(paddr, adc_temp_pkg::chan_ctrl_off)
      |=> mux_sel == $past(pwdata[7:2]))
      else $error("mux wrong");
   chk_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
      irq == (done_reg && ien_reg[0])) else $error("irq wrong"); // R6
   chk_hold_conv: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == adc_temp_pkg::convert_st |-> !sample_hold)
      else $error("tracking in convert"); // R5
   chk_ref_select: assert property (@(posedge pclk) // R7
      disable iff (!presetn)
      wr && hit(paddr, adc_temp_pkg::conv_cfg_off)
      |=> pos_ref_sel == $past(pwdata[1:0]))
      else $error("ref sel wrong");
endmodule : adc_temp_indicator_control

//--- verification/analog_front_model.sv
// Behavioural sensor, analog pins and comparator behind the multiplexer
module analog_front_model #(
   parameter logic [9:0] temp_level = 10'h1D3  // Sensor reading when powered
) (
   input  wire logic       pclk,          // System clock
   input  wire logic [5:0] mux_sel,       // Selected channel
   input  wire logic       sample_hold,   // Tracking while high
   input  wire logic [9:0] dac_code,      // Trial code
   input  wire logic       sensor_power,  // Sensor supply
   output logic            cmp_in         // Held input at or above trial
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] level;
   logic [9:0] held;
   // Pins are taken as set up for analog use; unpowered sensor reads zero
   always_comb begin
      if (mux_sel == adc_temp_pkg::temp_channel)
         level = sensor_power ? temp_level : 10'h000;
      else
         level = {4'h5, mux_sel};
   end
   // One shared hold stage for every channel
   always_ff @(posedge pclk) begin
      if (sample_hold)
         held <= level;
   end
   assign cmp_in = (held >= dac_code);
endmodule : analog_front_model

//--- verification/tb.sv
// Self-checking bench for the temperature indicator and converter control
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [9:0] temp_level = 10'h1D3;
   logic        pclk, presetn, psel, penable, pwrite, sleep_req, cmp_in;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, err, sample_hold, sensor_power;
   logic        sensor_high, fixed_ref_on, adc_power, irq, wake;
   logic [5:0]  mux_sel;
   logic [9:0]  dac_code;
   logic [1:0]  conv_ref_gain, comp_ref_gain, pos_ref_sel;
   int          err_total, cmp_count, cycles;

   adc_temp_indicator_control adc_temp_indicator_control_i (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .sleep_req, .cmp_in, .mux_sel, .sample_hold,
      .dac_code, .sensor_power, .sensor_high, .fixed_ref_on, .conv_ref_gain,
      .comp_ref_gain, .pos_ref_sel, .adc_power, .irq, .wake);
   analog_front_model #(.temp_level(temp_level)) analog_front_model_i (
      .pclk, .mux_sel, .sample_hold, .dac_code, .sensor_power, .cmp_in);

   task automatic give_verdict();
      if (err_total == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Look before the edge; values hold until the edge takes them
      do @(negedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic t_reset();
      apb(1'b0, adc_temp_pkg::ref_sensor_off, 32'h0);
      check(rd, {24'h0, adc_temp_pkg::ref_sensor_rst});
      apb(1'b0, adc_temp_pkg::chan_ctrl_off, 32'h0);
      check(rd, 32'h0);
      check({30'h0, sample_hold, sensor_power}, 32'h2);
   endtask : t_reset

   task automatic t_ref(input logic [31:0] wv, input logic [7:0] rv,
                        input logic [6:0] pins);
      apb(1'b1, adc_temp_pkg::ref_sensor_off, wv);
      apb(1'b0, adc_temp_pkg::ref_sensor_off, 32'h0);
      check(rd, {24'h0, rv});
      check({25'h0, fixed_ref_on, sensor_power, sensor_high, comp_ref_gain,
             conv_ref_gain}, {25'h0, pins});
   endtask : t_ref

   task automatic t_config();
      apb(1'b1, adc_temp_pkg::conv_cfg_off, 32'hFFFF_00B2);
      apb(1'b0, adc_temp_pkg::conv_cfg_off, 32'h0);
      check(rd, 32'h0000_00B2);
      check({30'h0, pos_ref_sel}, 32'h2);
   endtask : t_config

   task automatic t_refuse();
      apb(1'b1, adc_temp_pkg::chan_ctrl_off, 32'h0000_0002);
      apb(1'b0, adc_temp_pkg::chan_ctrl_off, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      check({31'h0, err}, 32'h1);
      apb(1'b0, adc_temp_pkg::dev_info_off, 32'h0);
      check(rd, {22'h0, adc_temp_pkg::dia_temp90_default});
   endtask : t_refuse

   task automatic t_convert(input logic [5:0] ch, input logic [9:0] exp);
      int n;
      apb(1'b1, adc_temp_pkg::chan_ctrl_off, {24'h0, ch, 2'b01});
      @(negedge pclk);
      check({25'h0, adc_power, mux_sel}, {25'h0, 1'b1, ch});
      // Sensor output needs time to settle on the hold stage
      if (ch == adc_temp_pkg::temp_channel)
         repeat (adc_temp_pkg::settle_cycles) @(posedge pclk);
      apb(1'b1, adc_temp_pkg::chan_ctrl_off, {24'h0, ch, 2'b11});
      n = 0;
      do begin
         apb(1'b0, adc_temp_pkg::chan_ctrl_off, 32'h0);
         n++;
      end while (rd[1] !== 1'b0 && n < 300);
      check(rd, {24'h0, ch, 2'b01});
      apb(1'b0, adc_temp_pkg::status_off, 32'h0);
      check({31'h0, rd[0]}, 32'h1);
      apb(1'b0, adc_temp_pkg::res_high_off, 32'h0);
      check(rd, {30'h0, exp[9:8]});
      apb(1'b0, adc_temp_pkg::res_low_off, 32'h0);
      check(rd, {24'h0, exp[7:0]});
      check({21'h0, sample_hold, dac_code}, {21'h0, 1'b1, exp});
      // Left-justified layout of the same result
      apb(1'b1, adc_temp_pkg::conv_cfg_off, 32'h0000_0032);
      apb(1'b0, adc_temp_pkg::res_high_off, 32'h0);
      check(rd, {24'h0, exp[9:2]});
      apb(1'b0, adc_temp_pkg::res_low_off, 32'h0);
      check(rd, {24'h0, exp[1:0], 6'h00});
      apb(1'b1, adc_temp_pkg::conv_cfg_off, 32'h0000_00B2);
   endtask : t_convert

   task automatic t_irq();
      check({30'h0, irq, wake}, 32'h0);
      apb(1'b1, adc_temp_pkg::irq_enable_off, 32'h1);
      @(negedge pclk);
      check({31'h0, irq}, 32'h1);
      @(posedge pclk);
      sleep_req <= 1'b1;
      repeat (4) @(posedge pclk);
      check({31'h0, wake}, 32'h1);
      apb(1'b1, adc_temp_pkg::status_off, 32'h1);
      @(posedge pclk);
      check({30'h0, irq, wake}, 32'h0);
      sleep_req <= 1'b0;
   endtask : t_irq

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // Cuts a hang short well past the expected run length
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         give_verdict();
      end
   end

   initial begin
      {presetn, psel, penable, pwrite, sleep_req} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      {err_total, cmp_count, cycles} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_ref(32'hFFFF_FFBF, 8'hFF, 7'h7F);
      t_ref(32'h0000_0020, 8'h60, 7'h20);
      t_config();
      t_refuse();
      t_convert(adc_temp_pkg::temp_channel, temp_level);
      t_convert(6'h05, 10'h145);
      t_irq();
      give_verdict();
   end
endmodule : tb
